// File: logic/bppc_params.svh
`ifndef BPPC_PARAMS_SVH
`define BPPC_PARAMS_SVH

// controller register offsets on apb
`define BPPC_OFS_CTRL    8'h00
`define BPPC_OFS_TXWORD  8'h04
`define BPPC_OFS_STATUS  8'h08
`define BPPC_OFS_CRC     8'h0c

// control register bit that restarts the stream tracker
`define BPPC_CTRL_CLR    0

// packet header field positions
`define BPPC_TYPE_HI     31
`define BPPC_TYPE_LO     29
`define BPPC_OP_HI       28
`define BPPC_OP_LO       27
`define BPPC_ADDR_HI     26
`define BPPC_ADDR_LO     13
`define BPPC_T1CNT_HI    10
`define BPPC_T2CNT_HI    26

// header type and operation codes
`define BPPC_HDR_T1      3'h1
`define BPPC_HDR_T2      3'h2
`define BPPC_OP_WR       2'h2

// device register address codes and command values
`define BPPC_DEV_CRC     14'h0000
`define BPPC_DEV_FAR     14'h0001
`define BPPC_DEV_CMD     14'h0004
`define BPPC_CMD_CRCRST  32'h0000_0001
`define BPPC_CMD_DESYNC  32'h0000_0002
`define BPPC_DEV_FRAME_DATA_IN_REG    14'h0002
`define BPPC_DEV_MASK    14'h0006
`define BPPC_DEV_CTL     14'h0008
`define BPPC_DEV_COR     14'h0009
`define BPPC_DEV_ID      14'h000c
`define BPPC_CMD_SWITCH  32'h0000_0007

// identity the far side expects (arbitrary value), and its error flag position
`define BPPC_ID_DEF      32'h0123_4567
`define BPPC_IDERR_BIT   13

// synchronization word default, checksum reset value
`define BPPC_SYNC_DEF    32'h5aa5_c33c
`define BPPC_CRC_RST     16'h0000

// link clock half period in pclk cycles
`define BPPC_CLK_HALF    4

`endif

// File: logic/bppc_pkg.sv
package bppc_pkg;

  typedef logic [15:0] bppc_crc_t;

  // stream tracker and byte sequencer states
  typedef enum logic [1:0] {TK_HUNT, TK_HDR, TK_DATA} bppc_trk_e;
  typedef enum logic [1:0] {SR_IDLE, SR_LOW, SR_HIGH} bppc_ser_e;

  // state of the controller top; the byte serializer it instantiates keeps its own
  typedef struct packed {
    bppc_trk_e   tk;
    logic [13:0] addr;
    logic        t1_seen;
    logic [26:0] cnt;
    bppc_crc_t   crc;
    logic        crc_chk;
    logic        crc_ok;
    logic        seq_err;
    logic        far_nz;
    logic        hold_vld;
    logic [31:0] hold;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        done_s1;
    logic        done_s2;
  } bppc_host_s;

  // state of the byte serializer, apart from its rise counter nrise_reg
  typedef struct packed {
    bppc_ser_e   st;
    logic [31:0] word;
    logic [1:0]  bidx;
    logic [7:0]  cnt;
    logic        clk;
    logic [7:0]  dat;
  } bppc_ser_s;

endpackage : bppc_pkg

// File: logic/bppc_link_if.sv
`timescale 1ns/10ps
interface bppc_link_if;
  logic        word_vld;
  logic [31:0] word;
  logic        rdy;
  logic        lclk;
  logic [7:0]  ldat;

  modport src (output word_vld, word, input rdy, lclk, ldat);
  modport ser (input word_vld, word, output rdy, lclk, ldat);
endinterface : bppc_link_if

// File: logic/bppc_ser.sv
`timescale 1ns/10ps
`include "bppc_params.svh"
module bppc_ser
  import bppc_pkg::*;
#(
  parameter int HALF = `BPPC_CLK_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  bppc_link_if.ser lk
);

  // a word is back in idle in the same cycle as its last link clock fall
  localparam int WC = 8 * HALF + 1;

  bppc_ser_s  r_reg;
  bppc_ser_s  r_next;
  logic       take;
  logic [2:0] nrise_reg;

  // most significant bit of a byte goes to data line zero
  function automatic logic [7:0] lane_map(input logic [7:0] b);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) o[i] = b[7-i];
    return o;
  endfunction : lane_map

  assign take     = (r_reg.st == SR_IDLE) && lk.word_vld;
  assign lk.rdy   = (r_reg.st == SR_IDLE);
  assign lk.lclk  = r_reg.clk;
  assign lk.ldat  = r_reg.dat;

  // four bytes per word, high byte first, data changes on falling link clock
  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      SR_IDLE: begin
        if (lk.word_vld) begin
          r_next.word = lk.word;
          r_next.bidx = 2'h0;
          r_next.dat  = lane_map(lk.word[31:24]);
          r_next.cnt  = 8'(HALF - 1);
          r_next.st   = SR_LOW;
        end
      end
      SR_LOW: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.clk = 1'b1;
          r_next.cnt = 8'(HALF - 1);
          r_next.st  = SR_HIGH;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      SR_HIGH: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.clk = 1'b0;
          r_next.cnt = 8'(HALF - 1);
          if (r_reg.bidx == 2'h3) begin
            r_next.st = SR_IDLE;
          end else begin
            r_next.bidx = r_reg.bidx + 2'h1;
            r_next.word = {r_reg.word[23:0], 8'h00};
            r_next.dat  = lane_map(r_reg.word[23:16]);
            r_next.st   = SR_LOW;
          end
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      default: r_next.st = SR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_reg <= '0;
    else          r_reg <= r_next;
  end

  // counts link clock rises within one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                    nrise_reg <= 3'h0;
    else if (take)                   nrise_reg <= 3'h0;
    else if (!r_reg.clk && r_next.clk) nrise_reg <= nrise_reg + 3'h1;
  end

  AST_FOUR_BYTES: assert property (@(posedge pclk) disable iff (!presetn)
    take |-> ##[WC:WC] (r_reg.st == SR_IDLE && nrise_reg == 3'h4))
    else $error("word did not take four link clock rises");

  AST_LANE_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(lk.lclk) |-> lk.ldat == lane_map(r_reg.word[31:24]))
    else $error("byte lane order wrong at link clock rise");

endmodule : bppc_ser

// File: logic/bppc_host.sv
`timescale 1ns/10ps
`include "bppc_params.svh"
module bppc_host
  import bppc_pkg::*;
#(
  parameter logic [31:0] SYNC_WORD = `BPPC_SYNC_DEF,
  parameter int          HALF      = `BPPC_CLK_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cfg_clk,
  output logic      [7:0]  cfg_data,
  input  wire logic        cfg_done
);

  bppc_host_s  r_reg;
  bppc_host_s  r_next;
  logic        acc;
  logic [31:0] w;
  logic [2:0]  hdr_type;
  logic [1:0]  hdr_op;
  logic [13:0] hdr_addr;
  logic [10:0] t1_cnt;
  logic [26:0] t2_cnt;
  logic        desync_w;
  logic        crc_rst_w;
  logic        busy;
  logic [31:0] status_w;
  bppc_crc_t   crc_upd;

  bppc_link_if lk ();

  // serial model: bit 0 takes input xor bit 15, taps at 2 and 15
  function automatic bppc_crc_t crc_step(input bppc_crc_t c_in,
                                         input logic [13:0] a,
                                         input logic [31:0] d);
    logic [45:0] s;
    bppc_crc_t   c;
    logic        fb;
    s  = {a, d};
    c  = c_in;
    fb = 1'b0;
    for (int i = 0; i < $bits(s); i++) begin
      fb = s[i] ^ c[15];
      c  = {c[14] ^ fb, c[13:2], c[1] ^ fb, c[0], fb};
    end
    return c;
  endfunction : crc_step

  // word handed to the serializer and seen by the tracker together
  assign lk.word_vld = r_reg.hold_vld;
  assign lk.word     = r_reg.hold;
  assign acc         = r_reg.hold_vld && lk.rdy;
  assign w           = r_reg.hold;

  // header field split
  assign hdr_type  = w[`BPPC_TYPE_HI:`BPPC_TYPE_LO];
  assign hdr_op    = w[`BPPC_OP_HI:`BPPC_OP_LO];
  assign hdr_addr  = w[`BPPC_ADDR_HI:`BPPC_ADDR_LO];
  assign t1_cnt    = w[`BPPC_T1CNT_HI:0];
  assign t2_cnt    = w[`BPPC_T2CNT_HI:0];

  // command words recognized inside data of the command register
  assign desync_w  = (r_reg.addr == `BPPC_DEV_CMD) && (w == `BPPC_CMD_DESYNC);
  assign crc_rst_w = (r_reg.addr == `BPPC_DEV_CMD) && (w == `BPPC_CMD_CRCRST);

  // address code repeats with each data word
  assign crc_upd   = crc_step(r_reg.crc, r_reg.addr, w);

  // status view
  assign busy      = r_reg.hold_vld || !lk.rdy;
  assign status_w  = {r_reg.crc, 9'h000, r_reg.far_nz, r_reg.seq_err, r_reg.crc_ok,
                      r_reg.crc_chk, r_reg.done_s2, (r_reg.tk != TK_HUNT), busy};

  // outputs straight from flops
  assign prdata    = r_reg.prdata;
  assign pready    = r_reg.pready;
  assign pslverr   = r_reg.pslverr;
  assign cfg_clk   = lk.lclk;
  assign cfg_data  = lk.ldat;

  // apb slave, done pin synchronizer and stream tracker
  always_comb begin
    r_next         = r_reg;
    r_next.done_s1 = cfg_done;
    r_next.done_s2 = r_reg.done_s1;
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    if (acc) begin
      r_next.hold_vld = 1'b0;
    end

    // access phase answered one cycle after it starts, unless a stream word write finds the holding register full
    if (psel && penable && !r_reg.pready) begin
      case (paddr)
        `BPPC_OFS_CTRL: begin
          r_next.pready = 1'b1;
          r_next.prdata = 32'h0000_0000;
          if (pwrite && pwdata[`BPPC_CTRL_CLR]) begin
            r_next.tk      = TK_HUNT;
            r_next.t1_seen = 1'b0;
            r_next.cnt     = 27'h0;
            r_next.crc     = `BPPC_CRC_RST;
            r_next.crc_chk = 1'b0;
            r_next.crc_ok  = 1'b0;
            r_next.seq_err = 1'b0;
            r_next.far_nz  = 1'b0;
          end
        end
        `BPPC_OFS_TXWORD: begin
          if (!pwrite) begin
            r_next.pready = 1'b1;
            r_next.prdata = r_reg.hold;
          end else if (!r_reg.hold_vld || acc) begin
            // words go out in the order software writes them
            r_next.hold     = pwdata;
            r_next.hold_vld = 1'b1;
            r_next.pready   = 1'b1;
          end
        end
        `BPPC_OFS_STATUS: begin
          r_next.pready = 1'b1;
          r_next.prdata = status_w;
        end
        `BPPC_OFS_CRC: begin
          r_next.pready = 1'b1;
          r_next.prdata = {16'h0000, r_reg.crc};
        end
        default: begin
          r_next.pready  = 1'b1;
          r_next.pslverr = 1'b1;
          r_next.prdata  = 32'h0000_0000;
        end
      endcase
    end

    // tracker follows each word as the device would; events win over clear
    if (acc) begin
      case (r_reg.tk)
        TK_HUNT: begin
          // words before sync are only clocking
          if (w == SYNC_WORD) begin
            r_next.tk = TK_HDR;
          end
        end
        TK_HDR: begin
          if (hdr_type == `BPPC_HDR_T1) begin
            r_next.addr    = hdr_addr;
            r_next.t1_seen = 1'b1;
            if (hdr_op == `BPPC_OP_WR && t1_cnt != 11'h000) begin
              r_next.cnt = {16'h0000, t1_cnt};
              r_next.tk  = TK_DATA;
            end
          end else if (hdr_type == `BPPC_HDR_T2) begin
            if (!r_reg.t1_seen) begin
              r_next.seq_err = 1'b1;
            end else if (hdr_op == `BPPC_OP_WR && t2_cnt != 27'h0) begin
              r_next.cnt = t2_cnt;
              r_next.tk  = TK_DATA;
            end
          end
          // any other type passes as a no-operation word
        end
        TK_DATA: begin
          r_next.crc = crc_rst_w ? `BPPC_CRC_RST : crc_upd;
          if (r_reg.addr == `BPPC_DEV_CRC) begin
            r_next.crc_chk = 1'b1;
            r_next.crc_ok  = (crc_upd == `BPPC_CRC_RST);
          end
          if (r_reg.addr == `BPPC_DEV_FAR && w != 32'h0000_0000) begin
            r_next.far_nz = 1'b1;
          end
          r_next.cnt = r_reg.cnt - 27'h1;
          if (desync_w) begin
            r_next.tk      = TK_HUNT;
            r_next.t1_seen = 1'b0;
          end else if (r_reg.cnt == 27'h1) begin
            r_next.tk = TK_HDR;
          end
        end
        default: r_next.tk = TK_HUNT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_reg <= '0;
    else          r_reg <= r_next;
  end

  bppc_ser #(
    .HALF (HALF)
  ) u_ser (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk.ser)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // word taken in each tracker state, and two cycles in hunt with t1_seen clear
  sequence s_take_hunt;
    r_reg.tk == TK_HUNT && acc;
  endsequence
  sequence s_take_hdr;
    r_reg.tk == TK_HDR && acc;
  endsequence
  sequence s_take_data;
    r_reg.tk == TK_DATA && acc;
  endsequence
  sequence s_stay_hunt;
    (r_reg.tk == TK_HUNT && !r_reg.t1_seen) [*2];
  endsequence

  AST_HUNT_IGNORE: assert property (
    s_take_hunt ##0 (w != SYNC_WORD) |=> r_reg.tk == TK_HUNT && $stable(r_reg.crc))
    else $error("word before sync changed tracker");

  AST_SYNC_ALIGN: assert property (
    s_take_hunt ##0 (w == SYNC_WORD) |=> r_reg.tk == TK_HDR)
    else $error("sync word did not start header decode");

  AST_T1_DECODE: assert property (
    s_take_hdr ##0 (hdr_type == `BPPC_HDR_T1 && hdr_op == `BPPC_OP_WR && t1_cnt != 11'h000)
    |=> r_reg.tk == TK_DATA && r_reg.cnt == {16'h0000, $past(t1_cnt)}
        && r_reg.addr == $past(hdr_addr))
    else $error("type 1 header decoded wrong");

  AST_T2_COUNT: assert property (
    s_take_hdr ##0 (hdr_type == `BPPC_HDR_T2 && r_reg.t1_seen && hdr_op == `BPPC_OP_WR
                    && t2_cnt != 27'h0)
    |=> r_reg.tk == TK_DATA && r_reg.cnt == $past(t2_cnt) && $stable(r_reg.addr))
    else $error("type 2 count or register wrong");

  AST_T2_ORDER: assert property (
    s_take_hdr ##0 (hdr_type == `BPPC_HDR_T2 && !r_reg.t1_seen) |=> r_reg.seq_err)
    else $error("type 2 without type 1 not flagged");

  AST_DATA_END: assert property (
    s_take_data ##0 (r_reg.cnt == 27'h1 && !desync_w) |=> r_reg.tk == TK_HDR)
    else $error("data portion did not end at count");

  AST_CRC_HOLD: assert property (
    s_take_hdr |=> $stable(r_reg.crc))
    else $error("header word changed checksum");

  AST_CRC_RESET: assert property (
    s_take_data ##0 crc_rst_w |=> r_reg.crc == `BPPC_CRC_RST)
    else $error("crc reset command did not clear checksum");

  AST_CRC_CHECK: assert property (
    s_take_data ##0 (r_reg.addr == `BPPC_DEV_CRC)
    |=> r_reg.crc_chk && (r_reg.crc_ok == (r_reg.crc == `BPPC_CRC_RST)))
    else $error("checksum check result wrong");

  AST_DESYNC: assert property (
    s_take_data ##0 desync_w |=> s_stay_hunt)
    else $error("desync did not drop alignment");

  AST_FAR_ZERO: assert property (
    s_take_data ##0 (r_reg.addr == `BPPC_DEV_FAR && w != 32'h0000_0000) |=> r_reg.far_nz)
    else $error("nonzero frame address not flagged");

  AST_APB_PULSE: assert property (
    r_reg.pready |=> !r_reg.pready)
    else $error("pready longer than one cycle");

  AST_TX_STALL: assert property (
    psel && penable && pwrite && paddr == `BPPC_OFS_TXWORD && r_reg.hold_vld && !acc
    && !r_reg.pready |=> !r_reg.pready)
    else $error("word accepted while holding register full");

  // bus access phases as this slave sees them
  sequence s_access;
    psel && penable && !r_reg.pready;
  endsequence
  sequence s_tx_free;
    s_access ##0 (pwrite && paddr == `BPPC_OFS_TXWORD && (!r_reg.hold_vld || acc));
  endsequence

  AST_APB_ANSWER: assert property (
    s_access ##0 !(pwrite && paddr == `BPPC_OFS_TXWORD) |=> r_reg.pready)
    else $error("access not answered in the next cycle");

  AST_ERR_MAP: assert property (
    s_access ##0 !(paddr inside {`BPPC_OFS_CTRL, `BPPC_OFS_TXWORD, `BPPC_OFS_STATUS,
                                 `BPPC_OFS_CRC}) |=> r_reg.pslverr && r_reg.pready)
    else $error("unmapped access not flagged");

  AST_TX_SEND: assert property (
    s_tx_free |=> r_reg.hold_vld && r_reg.pready && r_reg.hold == $past(pwdata))
    else $error("stream word not queued in write order");

  AST_ERR_PAIR: assert property (
    r_reg.pslverr |-> r_reg.pready)
    else $error("pslverr without pready");

  AST_CLEAR: assert property (
    s_access ##0 (pwrite && paddr == `BPPC_OFS_CTRL && pwdata[`BPPC_CTRL_CLR] && !acc)
    |=> r_reg.tk == TK_HUNT && r_reg.crc == `BPPC_CRC_RST && !r_reg.seq_err && !r_reg.far_nz)
    else $error("control clear did not restart tracker");

  AST_HOLD_DRAIN: assert property (
    acc && !(psel && penable && pwrite && paddr == `BPPC_OFS_TXWORD && !r_reg.pready)
    |=> !r_reg.hold_vld)
    else $error("held word not released after hand-over");

endmodule : bppc_host

// File: dv/bppc_dv_pkg.sv
package bppc_dv_pkg;

  // serial checksum: data lsb first, then the register code
  function automatic logic [15:0] upd(input logic [15:0] c, input logic [13:0] a,
                                      input logic [31:0] d);
    logic [45:0] s;
    logic        fb;
    s = {a, d};
    for (int i = 0; i < 46; i++) begin
      fb = s[i] ^ c[15];
      c  = {c[14] ^ fb, c[13:2], c[1] ^ fb, c[0], fb};
    end
    return c;
  endfunction : upd

  // write headers
  function automatic logic [31:0] t1(input logic [13:0] a, input logic [10:0] n);
    return {3'h1, 2'h2, a, 2'h0, n};
  endfunction : t1

  function automatic logic [31:0] t2(input logic [26:0] n);
    return {3'h2, 2'h2, n};
  endfunction : t2

endpackage : bppc_dv_pkg

// File: dv/bppc_dev_model.sv
`timescale 1ns/10ps
`include "bppc_params.svh"
module bppc_dev_model
  import bppc_dv_pkg::*;
#(
  parameter logic [31:0] SYNC_WORD = `BPPC_SYNC_DEF,
  parameter logic [31:0] DEV_ID    = `BPPC_ID_DEF
) (
  input  wire logic       cfg_clk,
  input  wire logic [7:0] cfg_data,
  output logic            cfg_done,
  output logic [15:0]     crc_o,
  output logic            ok_o,
  output logic [31:0]     ctl_o,
  output logic [31:0]     sel_o,
  output logic [31:0]     stat_o
);
  logic [31:0] sh = 32'h0;
  logic [1:0]  nb = 2'h0;
  logic        syn = 1'b0;
  logic [26:0] cnt = 27'h0;
  logic [13:0] adr = 14'h0;
  logic [7:0]  b;
  int          dn = 0;
  logic [31:0] config_options_reg = 32'h0;
  logic [31:0] msk = 32'h0;
  logic        id_ok = 1'b0;

  initial begin
    cfg_done = 1'b0;
    crc_o    = 16'h0;
    ok_o     = 1'b0;
    ctl_o    = 32'h0;
    sel_o    = 32'h0;
    stat_o   = 32'h0;
  end

  // byte capture on the rising link clock, word assembly and packet decode
  always @(posedge cfg_clk) begin
    for (int i = 0; i < 8; i++) b[7 - i] = cfg_data[i];
    sh = {sh[23:0], b};
    if (!syn) begin
      if (sh === SYNC_WORD) begin
        syn = 1'b1;
        nb = 2'h0;
        cfg_done = 1'b0;
      end
    end else begin
      nb = nb + 2'h1;
      if (nb == 2'h0 && cnt != 27'h0) begin
        cnt = cnt - 27'h1;
        crc_o = upd(crc_o, adr, sh);
        if (adr == `BPPC_DEV_CMD && sh == `BPPC_CMD_CRCRST) crc_o = 16'h0;
        if (adr == `BPPC_DEV_CRC) ok_o = (crc_o == 16'h0);
        if (adr == `BPPC_DEV_COR) config_options_reg = sh;
        if (adr == `BPPC_DEV_CMD && sh == `BPPC_CMD_SWITCH) sel_o = config_options_reg;
        if (adr == `BPPC_DEV_ID) id_ok = (sh == DEV_ID);
        if (adr == `BPPC_DEV_FRAME_DATA_IN_REG && !id_ok) stat_o[`BPPC_IDERR_BIT] = 1'b1;
        if (adr == `BPPC_DEV_MASK) msk = sh;
        if (adr == `BPPC_DEV_CTL) ctl_o = (ctl_o & ~msk) | (sh & msk);
        if (adr == `BPPC_DEV_CMD && sh == `BPPC_CMD_DESYNC) begin
          syn = 1'b0;
          if (ok_o) dn = 8;
        end
      end else if (nb == 2'h0 && sh[28:27] == `BPPC_OP_WR) begin
        if (sh[31:29] == `BPPC_HDR_T1) begin
          adr = sh[26:13];
          cnt = {16'h0, sh[10:0]};
        end else if (sh[31:29] == `BPPC_HDR_T2) cnt = sh[26:0];
      end // other types ignored
    end
    if (dn > 0) begin
      dn = dn - 1;
      if (dn == 0) cfg_done = 1'b1;
    end
  end
endmodule : bppc_dev_model

// File: dv/bppc_host_test.sv
`timescale 1ns/10ps
`include "bppc_params.svh"
module bppc_host_test import bppc_pkg::*, bppc_dv_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cfg_clk, cfg_done, mok, er;
  logic [7:0]  paddr, cfg_data;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] mctl, msel, mstat;
  logic [15:0] mcrc, ec;
  int          mismatches, checked, cv;

  bppc_host #(.HALF(2)) bppc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_clk(cfg_clk), .cfg_data(cfg_data),
    .cfg_done(cfg_done));
  bppc_dev_model bppc_dev_model_i (.cfg_clk(cfg_clk), .cfg_data(cfg_data),
    .cfg_done(cfg_done), .crc_o(mcrc), .ok_o(mok), .ctl_o(mctl), .sel_o(msel),
    .stat_o(mstat));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk

  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdc

  task tx(input logic [31:0] d);
    apb(1'b1, `BPPC_OFS_TXWORD, d);
  endtask : tx

  // single-word register write, tracked in the expected checksum
  task rw(input logic [13:0] a, input logic [31:0] d);
    tx(t1(a, 11'h1));
    tx(d);
    ec = upd(ec, a, d);
  endtask : rw

  task idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `BPPC_OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (rd[0] !== 1'b0) begin
      chk("idle", 32'h0, 32'h1);
      wrap_up();
    end
  endtask : idle

  // final checksum word; bad flips one bit so the fold cannot reach zero
  task crc_fix(input logic bad);
    for (cv = 0; cv < 65536; cv++) if (upd(ec, `BPPC_DEV_CRC, cv) == 16'h0) break;
    rw(`BPPC_DEV_CRC, 32'(cv) ^ {31'h0, bad});
  endtask : crc_fix

  // main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    mismatches = 0;
    checked    = 0;
    ec = 16'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`BPPC_OFS_STATUS, 32'h0, "status reset");
    rdc(`BPPC_OFS_CRC, 32'h0, "crc reset");
    rdc(`BPPC_OFS_CTRL, 32'h0, "ctrl read");
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, `BPPC_OFS_STATUS, 32'hffff_ffff);
    rdc(`BPPC_OFS_STATUS, 32'h0, "status ro");
    tx(32'hffff_ffff);
    tx(32'h5aa5_c300);
    idle();
    rdc(`BPPC_OFS_STATUS, 32'h0, "presync hunt");
    rdc(`BPPC_OFS_TXWORD, 32'h5aa5_c300, "last word");
    $display("test reset and hunt finished");
    tx(`BPPC_SYNC_DEF);
    rw(`BPPC_DEV_CMD, `BPPC_CMD_CRCRST);
    ec = 16'h0;
    rw(`BPPC_DEV_COR, 32'h0000_0003);
    rw(`BPPC_DEV_ID, `BPPC_ID_DEF);
    rw(`BPPC_DEV_CMD, `BPPC_CMD_SWITCH);
    tx(t1(14'h0003, 11'h2));
    for (int i = 0; i < 2; i++) begin
      tx(32'h1111_0000 + i);
      ec = upd(ec, 14'h0003, 32'h1111_0000 + i);
    end
    tx({3'h1, 2'h1, 14'h0003, 13'h0});
    tx({3'h7, 29'h1234});
    rw(`BPPC_DEV_FAR, 32'h0);
    tx(t1(14'h0002, 11'h0));
    tx(t2(27'h3));
    for (int i = 0; i < 3; i++) begin
      tx(32'hc0de_0000 ^ i);
      ec = upd(ec, 14'h0002, 32'hc0de_0000 ^ i);
    end
    rw(`BPPC_DEV_MASK, 32'h0000_00ff);
    rw(`BPPC_DEV_CTL, 32'h1234_5678);
    idle();
    rdc(`BPPC_OFS_CRC, {16'h0, ec}, "mid crc");
    chk("model crc", {16'h0, ec}, {16'h0, mcrc});
    chk("model clock select", 32'h0000_0003, msel);
    chk("model control", 32'h0000_0078, mctl);
    chk("model id_check_error", 32'h0, {31'h0, mstat[`BPPC_IDERR_BIT]});
    rdc(`BPPC_OFS_STATUS, {ec, 16'h0002}, "synced status");
    crc_fix(1'b0);
    rw(`BPPC_DEV_CMD, `BPPC_CMD_DESYNC);
    for (int i = 0; i < 4; i++) tx(32'hffff_ffff);
    idle();
    rdc(`BPPC_OFS_STATUS, {ec, 16'h001c}, "good end");
    chk("model ok", 32'h1, {31'h0, mok});
    $display("test good stream finished");
    apb(1'b1, `BPPC_OFS_CTRL, 32'h1);
    ec = 16'h0;
    tx(`BPPC_SYNC_DEF);
    tx(t2(27'h0));
    rw(`BPPC_DEV_FAR, 32'h5);
    rw(`BPPC_DEV_ID, ~`BPPC_ID_DEF);
    rw(`BPPC_DEV_FRAME_DATA_IN_REG, 32'h0);
    crc_fix(1'b1);
    idle();
    rdc(`BPPC_OFS_STATUS, {ec, 16'h006a}, "bad end");
    chk("model bad crc", 32'h0, {31'h0, mok});
    chk("model id_check_error set", 32'h1, {31'h0, mstat[`BPPC_IDERR_BIT]});
    $display("test bad stream finished");
    wrap_up();
  end
endmodule : bppc_host_test
